// *** hw/fsc_map.vh ***
// Register map, field positions and timing constants of the flash sequencer status block
`ifndef FSC_MAP_VH
`define FSC_MAP_VH
// APB byte addresses
`define FSC_ADDR_CTRL 12'h000
`define FSC_ADDR_STATH 12'h004
`define FSC_ADDR_ERR 12'h008
`define FSC_ADDR_IRQ_STAT 12'h00c
`define FSC_ADDR_IRQ_MASK 12'h010
// Control register fields
`define FSC_CTRL_START_BIT 7
`define FSC_CTRL_MODE_HI 2
`define FSC_CTRL_MODE_LO 0
`define FSC_CTRL_ERASE 8'h84
`define FSC_CTRL_WRITE 8'h81
`define FSC_CTRL_IDLE 8'h00
`define FSC_CTRL_RSVD_MASK 8'h78
// High status register fields
`define FSC_STATH_END_BIT 6
`define FSC_STATH_BUSY_BIT 0
// Error status fields
`define FSC_ERR_SEQ_BIT 4
`define FSC_ERR_WRITE_BIT 1
`define FSC_ERR_ERASE_BIT 0
`define FSC_ERR_MASK 8'h13
// Interrupt status fields
`define FSC_IRQ_DONE_BIT 0
`define FSC_IRQ_ERR_BIT 1
`define FSC_IRQ_WIDTH 2
// Reset values
`define FSC_RST_BYTE 8'h00
`define FSC_RST_IRQ 2'h0
// Default operation time, clock period and wind-down time in nanoseconds
`define FSC_OP_TIME_NS 1000
`define FSC_CLK_NS 5
`define FSC_FINISH_NS 20
`endif

// *** hw/fsc_engine.v ***
// Command engine: runs a flash command for a set time and reports its outcome
`timescale 1ns/1ps
`include "fsc_map.vh"
module fsc_engine #(
  parameter CNT_W = 16
) (
  input wire clk_in,
  input wire arst_n_in,
  input wire en_in,
  input wire start_in,
  input wire [2:0] mode_in,
  input wire [CNT_W-1:0] op_cycles_in,
  input wire seq_fail_in,
  input wire write_fail_in,
  input wire erase_fail_in,
  output reg busy_out,
  output reg done_out,
  output reg [7:0] err_out
);
  localparam [7:0] CMD_WRITE = `FSC_CTRL_WRITE;
  localparam [7:0] CMD_ERASE = `FSC_CTRL_ERASE;
  // Mode field of each command word
  localparam [2:0] MODE_WRITE = CMD_WRITE[`FSC_CTRL_MODE_HI:`FSC_CTRL_MODE_LO];
  localparam [2:0] MODE_ERASE = CMD_ERASE[`FSC_CTRL_MODE_HI:`FSC_CTRL_MODE_LO];
  reg [CNT_W-1:0] cnt_r;
  reg [2:0] mode_r;
  reg [7:0] err_acc_r;

  // Count down the operation, gather failures, publish errors at the end
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      busy_out <= 1'b0;
      done_out <= 1'b0;
      cnt_r <= {CNT_W{1'b0}};
      mode_r <= 3'h0;
      err_acc_r <= `FSC_RST_BYTE;
      err_out <= `FSC_RST_BYTE;
    end else if (en_in) begin
      done_out <= 1'b0;
      if (!busy_out && start_in) begin
        busy_out <= 1'b1;
        mode_r <= mode_in;
        cnt_r <= op_cycles_in;
        err_acc_r <= `FSC_RST_BYTE;
        err_out <= `FSC_RST_BYTE; // Cleared only at a new start [R12]
      end else if (busy_out) begin
        if (seq_fail_in)
          err_acc_r[`FSC_ERR_SEQ_BIT] <= 1'b1; // [R5]
        if (write_fail_in && mode_r == MODE_WRITE)
          err_acc_r[`FSC_ERR_WRITE_BIT] <= 1'b1; // [R6]
        if (erase_fail_in && mode_r == MODE_ERASE)
          err_acc_r[`FSC_ERR_ERASE_BIT] <= 1'b1; // [R7]
        if (mode_r != MODE_WRITE && mode_r != MODE_ERASE)
          err_acc_r[`FSC_ERR_SEQ_BIT] <= 1'b1; // Unknown command is a sequencer error [R5]
        if (cnt_r <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
          busy_out <= 1'b0;
          done_out <= 1'b1;
          err_out <= err_acc_r & `FSC_ERR_MASK; // Reserved bits forced zero [R8]
        end else begin
          cnt_r <= cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule

// *** hw/fsc_top.v ***
// Flash sequencer completion handshake and error status with an APB register port
// Summary of operation
// R1 - Software writes zero to the control register after seeing the end flag.
// R2 - End flag at status bit 6 falls once control is cleared and work done.
// R3 - Software polls for the flag falling only after it has seen it set.
// R4 - An eight-bit error status register reports the last command's errors.
// R5 - Error bit 4 is set on a sequencer error.
// R6 - Error bit 1 is set when a write command fails.
// R7 - Error bit 0 is set when an erase command fails.
// R8 - Error bits 7, 6, 5, 3 and 2 always read as zero.
// R9 - Software reads error status only after the sequencer has completed.
// R10 - End flag sets when the operation finishes while start command still held.
// R11 - Start bit 7 plus mode bits 2..0 launch; erase 0x84, write 0x81.
// R12 - Error bits stay stable from completion until the next command start.
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/1ps
`include "fsc_map.vh"
module fsc_top #(
  parameter CNT_W = 16,
  parameter OP_NS = `FSC_OP_TIME_NS
) (
  input wire clk_in,
  input wire arst_n_in,
  input wire clk_en_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [11:0] paddr_in,
  input wire [31:0] pwdata_in,
  output wire [31:0] prdata_out,
  output wire pready_out,
  output wire pslverr_out,
  input wire seq_fail_in,
  input wire write_fail_in,
  input wire erase_fail_in,
  output wire irq_out
);
  // Operation length in cycles, at least one
  localparam integer OP_CYC_RAW = OP_NS / `FSC_CLK_NS;
  localparam integer OP_CYC = (OP_CYC_RAW < 1) ? 1 : OP_CYC_RAW;
  localparam [CNT_W-1:0] OP_CYCLES = OP_CYC[CNT_W-1:0];
  // Wind-down after the control register clears before the flag falls
  localparam integer FIN_CYC = (`FSC_FINISH_NS + `FSC_CLK_NS - 1) / `FSC_CLK_NS;
  localparam [3:0] FIN_CYCLES = FIN_CYC[3:0];

  reg [7:0] ctrl_r;
  reg end_flag_r;
  reg [3:0] fin_cnt_r;
  reg fin_r;
  reg [`FSC_IRQ_WIDTH-1:0] irq_stat_r;
  reg [`FSC_IRQ_WIDTH-1:0] irq_mask_r;
  reg [31:0] rdata_r;
  // Failure pins come from the flash macro outside this clock domain
  reg [2:0] fail_s1_r;
  reg [2:0] fail_s2_r;
  wire busy;
  wire done;
  wire [7:0] err_stat;
  wire wr_en;
  wire rd_en;
  wire launch;
  wire known;
  // Address decodes and a cleared control register
  wire ctrl_clear;
  wire sel_ctrl;
  wire sel_irq_stat;
  wire sel_irq_mask;
  // Combinational next values of the interrupt status and read data
  reg [`FSC_IRQ_WIDTH-1:0] irq_set;
  reg [`FSC_IRQ_WIDTH-1:0] irq_clr;
  reg [`FSC_IRQ_WIDTH-1:0] irq_stat_nxt;
  reg [31:0] rdata_nxt;

  // Decode whether an address is a mapped register
  function addr_hit;
    input [11:0] a;
    begin
      addr_hit = (a == `FSC_ADDR_CTRL) || (a == `FSC_ADDR_STATH) ||
                 (a == `FSC_ADDR_ERR) || (a == `FSC_ADDR_IRQ_STAT) ||
                 (a == `FSC_ADDR_IRQ_MASK);
    end
  endfunction

  // Error byte with reserved bits masked [R8]
  function [7:0] err_stat_next;
    input [7:0] e;
    begin
      err_stat_next = e & `FSC_ERR_MASK;
    end
  endfunction

  // APB strobes: zero-wait slave, error on unmapped address
  // The slave never stalls, so every access phase ends in its first cycle
  assign pready_out = 1'b1;
  assign wr_en = psel_in && penable_in && pwrite_in && clk_en_in;
  assign rd_en = psel_in && !penable_in && !pwrite_in && clk_en_in;
  assign pslverr_out = psel_in && penable_in && !addr_hit(paddr_in);
  assign prdata_out = rdata_r;
  assign irq_out = |(irq_stat_r & irq_mask_r);

  // Register selects from the byte address
  assign sel_ctrl = (paddr_in == `FSC_ADDR_CTRL);
  assign sel_irq_stat = (paddr_in == `FSC_ADDR_IRQ_STAT);
  assign sel_irq_mask = (paddr_in == `FSC_ADDR_IRQ_MASK);
  assign ctrl_clear = (ctrl_r == `FSC_CTRL_IDLE);

  // Launch only on a start bit with a mode and clear upper bits [R11]
  // The done pulse blocks a second start in the cycle the end flag is set
  assign known = (ctrl_r == `FSC_CTRL_ERASE) || (ctrl_r == `FSC_CTRL_WRITE);
  assign launch = ctrl_r[`FSC_CTRL_START_BIT] && !end_flag_r && !fin_r && !done &&
                  ((ctrl_r & `FSC_CTRL_RSVD_MASK) == `FSC_RST_BYTE); // [R11]

  // Two-stage synchroniser for the failure inputs
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      fail_s1_r <= 3'h0;
      fail_s2_r <= 3'h0;
    end else if (clk_en_in) begin
      fail_s1_r <= {seq_fail_in, write_fail_in, erase_fail_in};
      fail_s2_r <= fail_s1_r;
    end
  end

  // Engine starts only from idle, so control writes while busy never relaunch
  fsc_engine #(
    .CNT_W(CNT_W)
  ) u_engine (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .en_in(clk_en_in),
    .start_in(launch && !busy),
    .mode_in(ctrl_r[`FSC_CTRL_MODE_HI:`FSC_CTRL_MODE_LO]),
    .op_cycles_in(OP_CYCLES),
    .seq_fail_in(fail_s2_r[2]),
    .write_fail_in(fail_s2_r[1]),
    .erase_fail_in(fail_s2_r[0]),
    .busy_out(busy),
    .done_out(done),
    .err_out(err_stat)
  );

  // Control register, end flag and its wind-down after clear
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctrl_r <= `FSC_RST_BYTE;
      end_flag_r <= 1'b0;
      fin_cnt_r <= 4'h0;
      fin_r <= 1'b0;
    end else if (clk_en_in) begin
      if (wr_en && sel_ctrl)
        ctrl_r <= pwdata_in[7:0];
      if (done && ctrl_r[`FSC_CTRL_START_BIT])
        end_flag_r <= 1'b1; // [R10]
      // Once software has cleared control, a short wind-down runs before
      // the flag falls, so polling sees the command fully retired
      if (end_flag_r && ctrl_clear && !fin_r && !busy) begin
        fin_r <= 1'b1;
        fin_cnt_r <= FIN_CYCLES;
      end else if (fin_r) begin
        if (fin_cnt_r <= 4'h1) begin
          fin_r <= 1'b0;
          end_flag_r <= 1'b0; // Falls after clear and wind-down [R2]
        end else begin
          fin_cnt_r <= fin_cnt_r - 4'h1;
        end
      end
    end
  end

  // Interrupt events of this cycle against the software clear; set wins [R10]
  always @* begin
    irq_set = `FSC_RST_IRQ;
    irq_set[`FSC_IRQ_DONE_BIT] = done;
    irq_set[`FSC_IRQ_ERR_BIT] = done && (|err_stat_next(err_stat));
    irq_clr = `FSC_RST_IRQ;
    if (wr_en && sel_irq_stat)
      irq_clr = pwdata_in[`FSC_IRQ_WIDTH-1:0];
    irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_set;
  end

  // Sticky interrupt status and its mask
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_stat_r <= `FSC_RST_IRQ;
      irq_mask_r <= `FSC_RST_IRQ;
    end else if (clk_en_in) begin
      if (wr_en && sel_irq_mask)
        irq_mask_r <= pwdata_in[`FSC_IRQ_WIDTH-1:0];
      irq_stat_r <= irq_stat_nxt;
    end
  end

  // Read multiplexer; unused bits and reserved error bits read as zero, control reads back all eight bits
  // Status bit 0 also covers the cycle in which an odd mode is accepted,
  // so software sees no gap between start and busy for odd modes; erase and write leave one cycle
  always @* begin
    rdata_nxt = 32'h0000_0000;
    case (paddr_in)
      `FSC_ADDR_CTRL: rdata_nxt[7:0] = ctrl_r;
      `FSC_ADDR_STATH: begin
        rdata_nxt[`FSC_STATH_END_BIT] = end_flag_r;
        rdata_nxt[`FSC_STATH_BUSY_BIT] = busy || fin_r || (launch && !known);
      end
      `FSC_ADDR_ERR: rdata_nxt[7:0] = err_stat_next(err_stat); // [R4] [R12]
      `FSC_ADDR_IRQ_STAT: rdata_nxt[`FSC_IRQ_WIDTH-1:0] = irq_stat_r;
      `FSC_ADDR_IRQ_MASK: rdata_nxt[`FSC_IRQ_WIDTH-1:0] = irq_mask_r;
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  // Read data captured in the setup cycle, held through the access phase
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_r <= 32'h0000_0000;
    end else if (rd_en) begin
      rdata_r <= rdata_nxt;
    end
  end
endmodule

// *** sim/fsc_top_asserts.sv ***
// Checker for the register port of the flash sequencer status block
`timescale 1ns/1ps
module fsc_chk (
  input wire clk_in,
  input wire arst_n_in,
  input wire clk_en_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [11:0] paddr_in,
  input wire [31:0] prdata_out,
  input wire pready_out,
  input wire pslverr_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  // Setup and access phase qualifiers
  wire su = psel_in && !penable_in && !pwrite_in && clk_en_in;
  wire ac = psel_in && penable_in;
  // Bus answer and decode
  property p_rdy; ac |-> pready_out; endproperty
  a_rdy: assert property (p_rdy) else $error("access not answered");
  property p_slv; ac && paddr_in > 12'h010 |-> pslverr_out; endproperty
  a_slv: assert property (p_slv) else $error("unmapped access accepted");
  property p_map; ac && paddr_in == 12'h008 |-> !pslverr_out; endproperty
  a_map: assert property (p_map) else $error("error status refused");
  // Read data contents
  property p_rsv; su && paddr_in == 12'h008 |=> prdata_out[7:5] == 3'h0 && prdata_out[3:2] == 2'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved error bit set");
  property p_hi; su && paddr_in == 12'h008 |=> prdata_out[31:8] == 24'h0; endproperty
  a_hi: assert property (p_hi) else $error("error status wider than a byte");
  property p_hold; !su |=> $stable(prdata_out); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_stat; su && paddr_in == 12'h004 |=> prdata_out[5:1] == 5'h0; endproperty
  a_stat: assert property (p_stat) else $error("stray status bit");
  property p_ctl; su && paddr_in == 12'h000 |=> prdata_out[31:8] == 24'h0; endproperty
  a_ctl: assert property (p_ctl) else $error("control wider than a byte");
endmodule
bind fsc_top fsc_chk u_chk (.*);

// *** sim/tb.sv ***
// Self-checking bench for the flash sequencer status block
`timescale 1ns/1ps
module tb;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic clk_en_in = 1'b1;
  logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0, rd;
  logic seq_fail_in = 1'b0, write_fail_in = 1'b0, erase_fail_in = 1'b0, slv;
  wire [31:0] prdata_out;
  wire pready_out, pslverr_out, irq_out;
  int n_fail = 0, n_tests = 0;
  logic [7:0] ctl [6] = '{8'h84, 8'h84, 8'h81, 8'h81, 8'h82, 8'h84};
  logic [2:0] fl [6] = '{3'h0, 3'h1, 3'h2, 3'h1, 3'h0, 3'h4};
  logic [7:0] ex [6] = '{8'h00, 8'h01, 8'h02, 8'h00, 8'h10, 8'h10};
  // Clock and design
  always #2.5 clk_in = ~clk_in;
  fsc_top #(.OP_NS(50)) DUT (.*);
  // Compare and count
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      $display("Error at %0t: got %h expected %h", $time, g, e);
      n_fail++;
    end
  endtask
  // One bus transfer, read data and error kept in rd and slv
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    do @(posedge clk_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    slv = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  // Poll the end flag until it reaches v
  task wait_end(input logic v);
    int k;
    k = 0;
    do begin
      apb(1'b0, 12'h004, 32'h0);
      k++;
    end while (rd[6] !== v && k < 200);
    chk(rd[6], v);
  endtask
  task t_reset;
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h014, 32'h0);
    chk({rd[31:1], slv}, 32'h1);
    chk(irq_out, 1'b0);
    $display("reset test done");
  endtask
  // Full command handshake with one failure pattern
  task t_cmd(input int i);
    apb(1'b1, 12'h010, 32'h0);
    {seq_fail_in, write_fail_in, erase_fail_in} <= fl[i];
    apb(1'b1, 12'h000, {24'h0, ctl[i]});
    wait_end(1'b1);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, {24'h0, ex[i]});
    chk(irq_out, 1'b0);
    apb(1'b1, 12'h010, 32'h3);
    #1 chk(irq_out, 1'b1);
    apb(1'b1, 12'h000, 32'h0);
    {seq_fail_in, write_fail_in, erase_fail_in} <= 3'h0;
    wait_end(1'b0);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, {24'h0, ex[i]});
    apb(1'b1, 12'h00c, 32'h3);
    #1 chk(irq_out, 1'b0);
    $display("command test %0d done", i);
  endtask
  // Clock enable low holds a written command before the engine starts it
  task t_freeze;
    apb(1'b1, 12'h010, 32'h3);
    apb(1'b1, 12'h000, 32'h84);
    clk_en_in <= 1'b0;
    repeat (30) @(posedge clk_in);
    chk(irq_out, 1'b0);
    clk_en_in <= 1'b1;
    wait_end(1'b1);
    chk(irq_out, 1'b1);
    apb(1'b1, 12'h000, 32'h0);
    wait_end(1'b0);
    apb(1'b1, 12'h00c, 32'h3);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h0);
    chk(irq_out, 1'b0);
    $display("freeze test done");
  endtask
  task summarize;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge clk_in);
    arst_n_in <= 1'b1;
    t_reset();
    for (int i = 0; i < 6; i++) t_cmd(i);
    t_freeze();
    summarize();
  end
  // Watchdog
  initial begin
    #100000;
    n_fail++;
    summarize();
  end
endmodule
